// ---- tcx_consts.vh ----
`ifndef TCX_CONSTS_VH
`define TCX_CONSTS_VH
// ==================================================
// Register word addresses
`define TCX_A_CTRL   4'h0
`define TCX_A_PER    4'h1
`define TCX_A_CNT    4'h2
`define TCX_A_CC0    4'h3
`define TCX_A_DT     4'h7
`define TCX_A_PAT    4'h8
`define TCX_A_STAT   4'h9
`define TCX_A_EVSEL  4'ha
`define TCX_A_CAPHI  4'hb
// ==================================================
// Control register bit positions
`define TCX_C_EN     0
`define TCX_C_PRE_LO 1
`define TCX_C_PRE_HI 3
`define TCX_C_EVCLK  4
`define TCX_C_DOWN   5
`define TCX_C_EVDIR  6
`define TCX_C_CAPT   7
`define TCX_C_SYNC   8
`define TCX_C_SPLIT  9
`define TCX_C_DTI    10
`define TCX_C_DTHALT 11
`define TCX_C_PGEN   12
`define TCX_C_DISTA  13
`define TCX_C_FLTEN  14
// ==================================================
// Status register bit positions
`define TCX_S_OVF    0
`define TCX_S_HUNF   1
`define TCX_S_CC0    2
`define TCX_S_FAULT  6
// ==================================================
// Reset values
`define TCX_RST_CTRL 16'h0000
`define TCX_RST_PER  16'hffff
`define TCX_RST_PAT  16'h0000
`define TCX_RST_DT   16'h0000
`endif

// ---- tcx_timer.v ----
// How it works
// - Counts prescaled clock or events, direction, period.
// - Four channels in type 0, two in type 1.
// - Whole unit is either compare or capture.
// - Chained units form one 32-bit counter.
// - Events clock, steer, capture and synchronise counter.
// - Split into two 8-bit counters only type 0.
// - Split halves share clock, own period, compares.
// - Split halves always count down, flag underflow.
// - Only low half raises compare flags, events.
// - Split gives eight single-slope PWM outputs.
// - Extension turns each of outputs 0-3 (low halves in split) into complementary pair.
// - Dead-time unit makes low and inverted high.
// - Four dead-time units, buffered 8-bit low/high.
// - Counter optionally halts during dead time.
// - Dead-time outputs override pins selected by mask.
// - Pattern generator drives buffered synchronised pattern.
// - Channel A optionally drives every port pin.
// - Pattern generator bypasses dead-time units.
// - Selected fault event disables extension outputs at once.
`timescale 1ns/1ns
`include "tcx_consts.vh"

module tcx_timer #(
	parameter NCH = 4,
	parameter DTW = 8
) (
	// Clock and reset
	input  wire        CLK,
	input  wire        RSTN,
	// Register port
	input  wire [3:0]  ADDR,
	input  wire [15:0] WDATA,
	input  wire        WSTB,
	input  wire        RSTB,
	output reg  [15:0] RDATA,
	// Event system and cascade partner
	input  wire [3:0]  EV_IN,
	input  wire [15:0] CAP_HI_IN,
	output reg         EV_OVF,
	output reg         EV_HUNF,
	output reg  [3:0]  EV_CC,
	// Port pins
	output reg  [7:0]  PIN_VAL,
	output reg  [7:0]  PIN_OVR,
	output reg         FAULT
);

	// ==================================================
	// Register storage
	reg  [15:0] ctrl_ff;
	reg  [15:0] per_ff;
	reg  [15:0] cnt_ff;
	reg  [15:0] nxt_cnt;
	reg  [15:0] dt_buf_ff;
	reg  [15:0] dt_ff;
	reg  [15:0] pat_buf_ff;
	reg  [15:0] pat_ff;
	reg  [15:0] caphi_ff;
	reg  [7:0]  evsel_ff;
	reg  [6:0]  stat_ff;
	reg  [9:0]  pre_ff;
	reg  [9:0]  pre_mask;
	wire [63:0] cc_w;
	reg         ovf;
	reg         hunf;
	reg  [7:0]  val;
	reg  [7:0]  ovr;
	reg  [15:0] rd;
	wire [3:0]  hit;
	wire [3:0]  cap0;
	wire [7:0]  wg;
	wire [3:0]  ls;
	wire [3:0]  hs;
	wire [3:0]  busy;

	// split exists only in type 0
	wire split   = ctrl_ff[`TCX_C_SPLIT] & (NCH == 4);
	wire capt    = ctrl_ff[`TCX_C_CAPT] & ~split;
	wire dti_en  = ctrl_ff[`TCX_C_DTI];
	wire pgen    = ctrl_ff[`TCX_C_PGEN];
	wire waveform_extension    = dti_en | pgen;
	wire ev_clk  = EV_IN[evsel_ff[1:0]];
	wire ev_dir  = EV_IN[evsel_ff[3:2]];
	wire ev_flt  = EV_IN[evsel_ff[7:6]];
	wire ev_sync = ctrl_ff[`TCX_C_SYNC] & ~capt & EV_IN[evsel_ff[5:4]];

	wire down = ctrl_ff[`TCX_C_DOWN] ^ (ctrl_ff[`TCX_C_EVDIR] & ev_dir);

	// halt while any dead time runs
	wire halt = ctrl_ff[`TCX_C_DTHALT] & dti_en & ~pgen & (|busy);

	wire [2:0] psel = ctrl_ff[`TCX_C_PRE_HI:`TCX_C_PRE_LO];

	// ==================================================
	// Clock source
	always @* begin
		case (psel)
			3'h1: pre_mask = 10'h000;
			3'h2: pre_mask = 10'h001;
			3'h3: pre_mask = 10'h003;
			3'h4: pre_mask = 10'h007;
			3'h5: pre_mask = 10'h03f;
			3'h6: pre_mask = 10'h0ff;
			3'h7: pre_mask = 10'h3ff;
			default: pre_mask = 10'h000;
		endcase
	end

	// The prescaler restarts whenever the unit is disabled, so each start sees a full divide.
	wire pre_hit = (psel != 3'h0) & ((pre_ff & pre_mask) == pre_mask);

	wire tick = ctrl_ff[`TCX_C_EN] & ~halt &
		(ctrl_ff[`TCX_C_EVCLK] ? ev_clk : pre_hit);

	// ==================================================
	// Counter
	// Counting up, a count written above the period runs on to the 16-bit wrap before it meets the period.
	always @* begin
		nxt_cnt = cnt_ff;
		ovf = 1'b0;
		hunf = 1'b0;
		if (ev_sync) begin
			nxt_cnt = (down | split) ? per_ff : 16'h0000;
		end else if (tick && split) begin
			if (cnt_ff[7:0] == 8'h00) begin
				nxt_cnt[7:0] = per_ff[7:0];
				ovf = 1'b1;
			end else begin
				nxt_cnt[7:0] = cnt_ff[7:0] - 8'h01;
			end
			if (cnt_ff[15:8] == 8'h00) begin
				nxt_cnt[15:8] = per_ff[15:8];
				hunf = 1'b1;
			end else begin
				nxt_cnt[15:8] = cnt_ff[15:8] - 8'h01;
			end
		end else if (tick && down) begin
			if (cnt_ff == 16'h0000) begin
				nxt_cnt = per_ff;
				ovf = 1'b1;
			end else begin
				nxt_cnt = cnt_ff - 16'h0001;
			end
		end else if (tick) begin
			if (cnt_ff == per_ff) begin
				nxt_cnt = 16'h0000;
				ovf = 1'b1;
			end else begin
				nxt_cnt = cnt_ff + 16'h0001;
			end
		end
	end

	// Buffers load at wrap, or at once while stopped.
	wire upd = ovf | ~ctrl_ff[`TCX_C_EN];

	// ==================================================
	// Channels
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_ch
			if (i < NCH) begin : g_on
				localparam [1:0] CI2 = i;
				localparam [3:0] CI4 = i;
				// Each channel owns its register; the flat bus gives every word one driver.
				reg  [15:0] ccr_ff;
				wire [1:0]  cidx = evsel_ff[5:4] + CI2;
				wire cap = capt & EV_IN[cidx];
				wire wsel = WSTB & (ADDR == (`TCX_A_CC0 + CI4));
				// compares look only at the low byte in split
				wire meq = split ? (cnt_ff[7:0] == ccr_ff[7:0]) :
					(cnt_ff == ccr_ff);
				assign cc_w[16*i +: 16] = ccr_ff;
				assign hit[i] = (tick & ~capt & meq) | cap;
				assign cap0[i] = cap;
				assign wg[i] = ~capt & (split ?
					(cnt_ff[7:0] < ccr_ff[7:0]) : (cnt_ff < ccr_ff));
				assign wg[4+i] = split & (cnt_ff[15:8] < ccr_ff[15:8]);
				always @(posedge CLK or negedge RSTN) begin
					if (!RSTN) begin
						ccr_ff <= 16'h0000;
					end else if (cap) begin
						ccr_ff <= cnt_ff;
					end else if (wsel) begin
						ccr_ff <= WDATA;
					end
				end
			end else begin : g_off
				// channels three and four absent in type 1
				assign cc_w[16*i +: 16] = 16'h0000;
				assign hit[i] = 1'b0;
				assign cap0[i] = 1'b0;
				assign wg[i] = 1'b0;
				assign wg[4+i] = 1'b0;
			end
		end
	endgenerate

	// ==================================================
	// Dead-time units
	genvar k;
	generate
		for (k = 0; k < 4; k = k + 1) begin : g_dti
			reg           prev_ff;
			reg [DTW-1:0] dcnt_ff;
			reg           ls_ff;
			reg           hs_ff;
			assign ls[k] = ls_ff;
			assign hs[k] = hs_ff;
			assign busy[k] = (wg[k] != prev_ff) | (dcnt_ff != {DTW{1'b0}});
			always @(posedge CLK or negedge RSTN) begin
				if (!RSTN) begin
					prev_ff <= 1'b0;
					dcnt_ff <= {DTW{1'b0}};
					ls_ff <= 1'b0;
					hs_ff <= 1'b0;
				end else begin
					prev_ff <= wg[k];
					// A new edge inside a running dead time restarts it from the new setting.
					if (wg[k] != prev_ff) begin
						// low side delay on rise, high side on fall
						dcnt_ff <= wg[k] ? dt_ff[DTW-1:0] : dt_ff[15:8];
						// both off while dead time runs
						ls_ff <= 1'b0;
						hs_ff <= 1'b0;
					end else if (dcnt_ff != {DTW{1'b0}}) begin
						dcnt_ff <= dcnt_ff - {{(DTW-1){1'b0}}, 1'b1};
						ls_ff <= 1'b0;
						hs_ff <= 1'b0;
					end else begin
						// low side follows, high side inverted
						ls_ff <= wg[k];
						hs_ff <= ~wg[k];
					end
				end
			end
		end
	endgenerate

	// ==================================================
	// Pin selection
	wire flt_now = stat_ff[`TCX_S_FAULT] |
		(ctrl_ff[`TCX_C_FLTEN] & ev_flt);

	always @* begin
		// Pin 2k carries the low side of unit k and pin 2k+1 its high side.
		if (pgen) begin
			// pattern path skips the dead-time units
			// channel A copied to every pin
			val = ctrl_ff[`TCX_C_DISTA] ? {8{wg[0]}} : pat_ff[7:0];
			ovr = pat_ff[15:8];
		end else if (dti_en) begin
			val = {hs[3], ls[3], hs[2], ls[2], hs[1], ls[1], hs[0], ls[0]};
			ovr = pat_ff[15:8];
		end else if (split) begin
			val = wg;
			ovr = 8'hff;
		end else begin
			val = {4'h0, wg[3:0]};
			ovr = (NCH == 4) ? 8'h0f : 8'h03;
		end
		if (waveform_extension && flt_now) begin
			val = 8'h00;
		end
	end

	// ==================================================
	// Read multiplexer
	always @* begin
		case (ADDR)
			`TCX_A_CTRL:  rd = ctrl_ff;
			`TCX_A_PER:   rd = per_ff;
			`TCX_A_CNT:   rd = cnt_ff;
			`TCX_A_CC0:   rd = cc_w[15:0];
			4'h4:         rd = cc_w[31:16];
			4'h5:         rd = cc_w[47:32];
			4'h6:         rd = cc_w[63:48];
			`TCX_A_DT:    rd = dt_buf_ff;
			`TCX_A_PAT:   rd = pat_buf_ff;
			`TCX_A_STAT:  rd = {9'h000, stat_ff};
			`TCX_A_EVSEL: rd = {8'h00, evsel_ff};
			`TCX_A_CAPHI: rd = caphi_ff;
			default:      rd = 16'h0000;
		endcase
	end

	wire wr_stat = WSTB & (ADDR == `TCX_A_STAT);
	// The fault bit is set by the event alone, so a clear sticks once the event is gone.
	wire [6:0] set_stat = {ctrl_ff[`TCX_C_FLTEN] & ev_flt, hit, hunf, ovf};

	// ==================================================
	// Registers and outputs
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_ff <= `TCX_RST_CTRL;
			per_ff <= `TCX_RST_PER;
			cnt_ff <= 16'h0000;
			dt_buf_ff <= `TCX_RST_DT;
			dt_ff <= `TCX_RST_DT;
			pat_buf_ff <= `TCX_RST_PAT;
			pat_ff <= `TCX_RST_PAT;
			caphi_ff <= 16'h0000;
			evsel_ff <= 8'h00;
			stat_ff <= 7'h00;
			pre_ff <= 10'h000;
			RDATA <= 16'h0000;
			EV_OVF <= 1'b0;
			EV_HUNF <= 1'b0;
			EV_CC <= 4'h0;
			PIN_VAL <= 8'h00;
			PIN_OVR <= 8'h00;
			FAULT <= 1'b0;
		end else begin
			pre_ff <= ctrl_ff[`TCX_C_EN] ? pre_ff + 10'h001 : 10'h000;
			if (WSTB && ADDR == `TCX_A_CTRL) begin
				ctrl_ff <= WDATA;
			end
			if (WSTB && ADDR == `TCX_A_PER) begin
				per_ff <= WDATA;
			end
			if (WSTB && ADDR == `TCX_A_EVSEL) begin
				evsel_ff <= WDATA[7:0];
			end
			if (WSTB && ADDR == `TCX_A_CNT) begin
				cnt_ff <= WDATA;
			end else begin
				cnt_ff <= nxt_cnt;
			end
			if (WSTB && ADDR == `TCX_A_DT) begin
				dt_buf_ff <= WDATA;
			end
			if (WSTB && ADDR == `TCX_A_PAT) begin
				pat_buf_ff <= WDATA;
			end
			// dead time takes effect at the update
			// pattern changes only at the update
			if (upd) begin
				dt_ff <= dt_buf_ff;
				pat_ff <= pat_buf_ff;
			end
			// partner's count captured alongside channel 0
			if (cap0[0]) begin
				caphi_ff <= CAP_HI_IN;
			end
			// Set wins over a write-one clear in the same cycle.
			stat_ff <= (stat_ff & ~(wr_stat ? WDATA[6:0] : 7'h00)) | set_stat;
			RDATA <= RSTB ? rd : 16'h0000;
			// overflow event clocks a chained partner
			EV_OVF <= ovf;
			EV_HUNF <= hunf;
			EV_CC <= hit;
			PIN_VAL <= val;
			PIN_OVR <= ovr;
			FAULT <= waveform_extension & flt_now;
		end
	end

endmodule

// ---- tcx_timer_asserts.sv ----
`timescale 1ns/1ns
`include "tcx_consts.vh"

module tcx_chk #(
	parameter NCH = 4,
	parameter DTW = 8
) (
	// Clock, reset and register port
	input wire        CLK,
	input wire        RSTN,
	input wire [3:0]  ADDR,
	input wire [15:0] WDATA,
	input wire        WSTB,
	input wire        RSTB,
	input wire [15:0] RDATA,
	// Events and pins
	input wire [3:0]  EV_IN,
	input wire [15:0] CAP_HI_IN,
	input wire        EV_OVF,
	input wire        EV_HUNF,
	input wire [3:0]  EV_CC,
	input wire [7:0]  PIN_VAL,
	input wire [7:0]  PIN_OVR,
	input wire        FAULT
);
	// ==================================================
	// Shadows
	// Only the ports are visible, so the mode words are rebuilt from the writes.
	reg [15:0] ctrl_ff;
	reg [7:0]  evsel_ff;
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_ff <= 16'h0000;
			evsel_ff <= 8'h00;
		end else if (WSTB) begin
			if (ADDR == `TCX_A_CTRL)
				ctrl_ff <= WDATA;
			if (ADDR == `TCX_A_EVSEL)
				evsel_ff <= WDATA[7:0];
		end
	end
	wire ext_on = ctrl_ff[`TCX_C_DTI] | ctrl_ff[`TCX_C_PGEN];
	wire pair_mode = ctrl_ff[`TCX_C_DTI] & ~ctrl_ff[`TCX_C_PGEN] & ~ctrl_ff[`TCX_C_SPLIT];
	wire flt_req = ctrl_ff[`TCX_C_FLTEN] & ext_on & EV_IN[evsel_ff[7:6]];
	// ==================================================
	// Properties
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	a_rdata_idle: assert property (!$past(RSTB) |-> RDATA == 16'h0000)
		else $error("read data not zero outside a read");
	a_ctrl_back: assert property (RSTB && ADDR == `TCX_A_CTRL |=> RDATA[14:0] == $past(ctrl_ff[14:0]))
		else $error("control word read back wrong");
	a_unmapped_zero: assert property (RSTB && ADDR > `TCX_A_CAPHI |=> RDATA == 16'h0000)
		else $error("unmapped word not zero");
	a_hunf_split: assert property (EV_HUNF |-> $past(ctrl_ff[`TCX_C_SPLIT]))
		else $error("high underflow outside split mode");
	a_no_shoot: assert property ($past(pair_mode) |->
		((PIN_VAL >> 1) & PIN_VAL & 8'h55) == 8'h00)
		else $error("both sides of a pair active");
	a_fault_fast: assert property (flt_req && !WSTB |=> FAULT)
		else $error("fault not raised in one cycle");
	a_fault_zero: assert property (FAULT |-> PIN_VAL == 8'h00)
		else $error("pins not off during fault");
	a_fault_hold: assert property (FAULT && !WSTB && !$past(WSTB) |=> FAULT)
		else $error("fault dropped without software");
	c_fault: cover property (FAULT);
	c_hunf: cover property (EV_HUNF);
	c_read: cover property (RSTB ##1 RDATA != 16'h0000);
endmodule

bind tcx_timer tcx_chk #(.NCH(NCH), .DTW(DTW)) tcx_chk_inst (.*);

// ---- tcx_pwr_drv.sv ----
`timescale 1ns/1ns

// Gate driver pair model: reports a trip as a fault event one cycle later,
// and counts cycles of shoot-through and of dead time on bridge 0.
module tcx_pwr_drv (
	input wire       clk,
	input wire [7:0] pin_val,
	input wire [7:0] pin_ovr,
	input wire       trip,
	output reg       flt_ev,
	output int       shoot_cnt,
	output int       dead_cnt
);
	initial begin
		flt_ev = 1'b0;
		shoot_cnt = 0;
		dead_cnt = 0;
	end
	always @(posedge clk) begin
		flt_ev <= trip;
		if (pin_ovr[1:0] == 2'b11) begin
			if (pin_val[1:0] == 2'b11)
				shoot_cnt <= shoot_cnt + 1;
			if (pin_val[1:0] == 2'b00)
				dead_cnt <= dead_cnt + 1;
		end
	end
endmodule

// ---- timer_counter_split_deadtime_tb_top.sv ----
`timescale 1ns/1ns
`include "tcx_consts.vh"

module timer_counter_split_deadtime_tb_top;
	reg         CLK, RSTN, WSTB, RSTB, trip, rd_ff;
	reg [3:0]   ADDR;
	reg [15:0]  WDATA, CAP_HI_IN;
	wire [15:0] RDATA;
	wire        EV_OVF, EV_HUNF, FAULT, flt_ev;
	wire [3:0]  EV_CC;
	wire [7:0]  PIN_VAL, PIN_OVR;
	wire [3:0]  EV_IN = {flt_ev, 3'h0};
	int         shoot_cnt, dead_cnt, errors, total_checks, n, p, s0, c_cc;
	logic [15:0] exp_q[$];

	tcx_timer #(.NCH(4), .DTW(8)) tcx_timer_inst (.*);
	tcx_pwr_drv tcx_pwr_drv_inst (.clk(CLK), .pin_val(PIN_VAL), .pin_ovr(PIN_OVR), .trip(trip),
		.flt_ev(flt_ev), .shoot_cnt(shoot_cnt), .dead_cnt(dead_cnt));

	// ==================================================
	// Bus tasks and checking
	task chk(input string nm, input [15:0] e, input [15:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input [3:0] a, input [15:0] d);
		@(posedge CLK);
		ADDR <= a; WDATA <= d; WSTB <= 1'b1;
		@(posedge CLK);
		WSTB <= 1'b0;
	endtask
	task rd(input [3:0] a, input [15:0] e);
		@(posedge CLK);
		ADDR <= a; RSTB <= 1'b1; exp_q.push_back(e);
		@(posedge CLK);
		RSTB <= 1'b0;
	endtask
	// Counts the cycles between two pulses of EV_OVF or, with hi set, of EV_HUNF.
	task gap(input bit hi, output int c);
		c = 0;
		while ((hi ? EV_HUNF : EV_OVF) !== 1'b1 && c < 600) begin @(posedge CLK); c++; end
		@(posedge CLK);
		c = 1;
		while ((hi ? EV_HUNF : EV_OVF) !== 1'b1 && c < 600) begin @(posedge CLK); c++; end
	endtask
	task conclude;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Read data stand only in the cycle after the strobe.
	always @(posedge CLK) begin
		if (rd_ff)
			chk("RDATA", exp_q.pop_front(), RDATA);
		rd_ff <= RSTB;
	end

	// ==================================================
	// Clock, watchdog and tests
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	initial begin
		#200000;
		errors++;
		conclude;
	end
	initial begin
		RSTN = 0; WSTB = 0; RSTB = 0; ADDR = 0; WDATA = 0; trip = 0; rd_ff = 0;
		errors = 0; total_checks = 0;
		void'($urandom(69));
		CAP_HI_IN = $urandom;
		repeat (6) @(posedge CLK);
		RSTN <= 1'b1;
		rd(`TCX_A_CTRL, `TCX_RST_CTRL);
		rd(`TCX_A_PER, `TCX_RST_PER);
		rd(`TCX_A_DT, `TCX_RST_DT);
		rd(`TCX_A_PAT, `TCX_RST_PAT);
		for (n = 12; n < 16; n++) begin wr(n[3:0], 16'hffff); rd(n[3:0], 16'h0000); end
		for (n = 1; n < 8; n++) if (n != 2) begin p = $urandom; wr(n[3:0], p[15:0]); rd(n[3:0], p[15:0]); end
		p = 5 + $urandom % 20;
		wr(`TCX_A_PER, p[15:0]); wr(`TCX_A_CTRL, 16'h0003);
		gap(0, n); chk("up period", p + 1, n);
		wr(`TCX_A_CTRL, 16'h0023);
		gap(0, n); chk("down period", p + 1, n);
		wr(`TCX_A_CTRL, 16'h0000); wr(`TCX_A_PER, {p[7:0] + 8'h03, p[7:0]}); wr(`TCX_A_CTRL, 16'h0203);
		gap(1, n); chk("high period", p + 4, n);
		gap(0, n); chk("low period", p + 1, n);
		wr(`TCX_A_CTRL, 16'h0000); wr(`TCX_A_PER, 16'h0013); wr(`TCX_A_CC0, 16'h0008);
		wr(`TCX_A_CNT, 16'h0000);
		wr(`TCX_A_DT, 16'h0303); wr(`TCX_A_PAT, 16'hff00); wr(`TCX_A_CTRL, 16'h0403);
		// Plain mode may drive both pins of pair 0 high, so shoot-through counts from here.
		repeat (2) @(posedge CLK);
		n = dead_cnt;
		s0 = shoot_cnt;
		c_cc = 0;
		// Eighty cycles are exactly four periods, so channel 0 matches four times.
		repeat (80) begin
			@(posedge CLK);
			c_cc += EV_CC[0];
		end
		chk("compare events", 16'h0004, c_cc);
		chk("override", 16'h00ff, PIN_OVR);
		chk("dead time", 16'h0001, dead_cnt > n);
		wr(`TCX_A_EVSEL, 16'h00c0); wr(`TCX_A_CTRL, 16'h4403);
		trip <= 1'b1;
		repeat (3) @(posedge CLK);
		chk("fault", 16'h0001, FAULT);
		chk("fault pins", 16'h0000, PIN_VAL);
		trip <= 1'b0;
		repeat (2) @(posedge CLK);
		wr(`TCX_A_STAT, 16'h0040);
		repeat (2) @(posedge CLK);
		chk("fault clear", 16'h0000, FAULT);
		chk("shoot", 16'h0000, shoot_cnt - s0);
		p = $urandom;
		wr(`TCX_A_CTRL, 16'h0000); wr(`TCX_A_PAT, {8'hff, p[7:0]}); wr(`TCX_A_CTRL, 16'h1400);
		repeat (3) @(posedge CLK);
		chk("pattern", {8'h00, p[7:0]}, PIN_VAL);
		wr(`TCX_A_CNT, 16'h0000);
		wr(`TCX_A_CTRL, 16'h3400);
		repeat (3) @(posedge CLK);
		chk("distribute", 16'h00ff, PIN_VAL);
		wr(`TCX_A_EVSEL, 16'h0030);
		wr(`TCX_A_CTRL, 16'h0081);
		trip <= 1'b1;
		repeat (3) @(posedge CLK);
		trip <= 1'b0;
		repeat (2) @(posedge CLK);
		rd(`TCX_A_CAPHI, CAP_HI_IN);
		repeat (3) @(posedge CLK);
		conclude;
	end
endmodule
